// ### src/eia_defines.svh
// Functional notes
// - Operand address reaches every data memory section
// - Add with carry, five arithmetic flags
// - Plain add, same five arithmetic flags
// - AND to register or memory, zero only
// - OR to register or memory, zero only
// - Clear byte or bit, no flags
// - Invert operand, zero flag only
// - Add six per nibble above nine
// - Adjust constant added, result into memory
// - Decimal adjust touches carry only
// - Decrement operand, zero flag only
// - Increment operand, zero flag only
// - Move either direction, flags untouched
// - Rotate left, bit seven wraps
// - Rotate left through carry
// - Rotate right, bit zero wraps
// - Rotate right through carry
// - Subtract operand and inverted carry
// - Borrow clears carry, six flags updated
`ifndef EIA_DEFINES_SVH
`define EIA_DEFINES_SVH

// Data path width and default linear address width
`define EIA_DATA_W 8
`define EIA_ADDR_W_DEF 12
`define EIA_BIT_W 3

// Constants of the data path
`define EIA_ZERO_BYTE 8'h00
`define EIA_ONE_BYTE 8'h01
`define EIA_MSB 7
`define EIA_LSB 0
`define EIA_NIB_HI 7:4
`define EIA_NIB_LO 3:0
`define EIA_BCD_LIMIT 4'h9
`define EIA_ADJ_NONE 8'h00
`define EIA_ADJ_LO 8'h06
`define EIA_ADJ_HI 8'h60

// Reset values
`define EIA_ACC_RST 8'h00
`define EIA_FLAG_RST 1'b0

`endif

// ### src/eia_ext_alu.sv
`timescale 1ns/1ps
`include "eia_defines.svh"

module eia_ext_alu #(
    parameter int ADDR_W = `EIA_ADDR_W_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    // Instruction request
    input wire logic start,
    input wire eia_pkg::eia_req_s req,
    input wire logic [ADDR_W-1:0] req_addr,
    output logic ready,
    output logic done,
    // Data memory port, one cycle read latency
    output logic mem_rd_en,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr_en,
    output logic [7:0] mem_wdata,
    // Load of register and flags by the rest of the core
    input wire logic state_load,
    input wire logic [7:0] state_load_acc,
    input wire eia_pkg::eia_flags_s state_load_flags,
    // Architectural state
    output logic [7:0] working_register,
    output eia_pkg::eia_flags_s status
);
    import eia_pkg::*;

    // Sequencer states
    typedef enum logic [1:0] {
        eia_idle,
        eia_read,
        eia_exec,
        eia_done
    } eia_state_e;

    // Refuse widths the memory map cannot use
    if (ADDR_W < 1 || ADDR_W > 16) begin : g_addr_chk
        $error("eia_ext_alu: ADDR_W out of range");
    end

    // Byte adder shared by add, add with carry and subtract
    function automatic eia_sum_s add8(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin,
        input eia_flags_s old
    );
        logic [8:0] full;
        logic [4:0] low;
        logic c7;
        eia_sum_s r;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[`EIA_NIB_LO]} + {1'b0, b[`EIA_NIB_LO]}
            + {4'h0, cin};
        c7 = a[`EIA_MSB] ^ b[`EIA_MSB] ^ full[`EIA_MSB];
        r.sum = full[7:0];
        r.flags = old;
        r.flags.carry_flag = full[8];
        r.flags.half_carry_flag = low[4];
        r.flags.twos_complement_range_flag = c7 ^ full[8];
        r.flags.zero_flag = (full[7:0] == `EIA_ZERO_BYTE);
        r.flags.signed_carry_flag = c7 ^ full[8] ^ full[`EIA_MSB];
        return r;
    endfunction

    // Zero test used by every logic and count result
    function automatic logic is_zero(input logic [7:0] v);
        return v == `EIA_ZERO_BYTE;
    endfunction

    // Shift toward bit seven, fill bit enters at bit zero
    function automatic logic [7:0] rot_left(input logic [7:0] v,
        input logic fill);
        return {v[`EIA_MSB-1:`EIA_LSB], fill};
    endfunction

    // Shift toward bit zero, fill bit enters at bit seven
    function automatic logic [7:0] rot_right(input logic [7:0] v,
        input logic fill);
        return {fill, v[`EIA_MSB:`EIA_LSB+1]};
    endfunction

    // Sequencer and latched request
    eia_state_e state_reg;
    eia_op_e op_reg;
    logic [2:0] bit_reg;

    // Combinational results of the execute cycle
    logic [7:0] res;
    logic to_mem;
    logic to_reg;
    eia_flags_s flags_next;
    eia_sum_s ar;
    logic [7:0] adj;
    logic [8:0] daa_sum;
    logic lo_fix;
    logic hi_fix;

    // Request accepted only while idle
    assign ready = (state_reg == eia_idle);

    // Sequencer: idle, read operand, execute, done
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= eia_idle;
        end else begin
            case (state_reg)
                eia_idle: begin
                    // Wait for a request
                    if (start) begin
                        state_reg <= eia_read;
                    end
                end
                eia_read: begin
                    // Read strobe high this cycle, operand valid in the next
                    state_reg <= eia_exec;
                end
                eia_exec: begin
                    // Operand captured and result written
                    state_reg <= eia_done;
                end
                eia_done: begin
                    // Done pulse stands for this cycle
                    state_reg <= eia_idle;
                end
                default: begin
                    state_reg <= eia_idle;
                end
            endcase
        end
    end

    // Request capture: operation and bit position
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            op_reg <= ext_move;
            bit_reg <= '0;
        end else if (start && ready) begin
            op_reg <= req.op;
            bit_reg <= req.bit_sel;
        end
    end

    // Memory read strobe and address, from flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_rd_en <= 1'b0;
            mem_addr <= '0;
        end else begin
            mem_rd_en <= start && ready;
            if (start && ready) begin
                mem_addr <= req_addr;
            end
        end
    end

    // Decimal adjust correction terms
    always_comb begin
        lo_fix = (working_register[`EIA_NIB_LO] > `EIA_BCD_LIMIT)
            || status.half_carry_flag;
        hi_fix = (working_register[`EIA_NIB_HI] > `EIA_BCD_LIMIT)
            || status.carry_flag;
        adj = (lo_fix ? `EIA_ADJ_LO : `EIA_ADJ_NONE)
            | (hi_fix ? `EIA_ADJ_HI : `EIA_ADJ_NONE);
        daa_sum = {1'b0, working_register} + {1'b0, adj};
    end

    // Result, destination and flag selection
    always_comb begin
        res = mem_rdata;
        to_mem = 1'b0;
        to_reg = 1'b0;
        flags_next = status;
        ar = add8(working_register, mem_rdata, 1'b0, status);
        case (op_reg)
            ext_add_with_carry, ext_add_with_carry_to_mem: begin
                // Accumulator plus operand plus carry
                ar = add8(working_register, mem_rdata,
                    status.carry_flag, status);
                res = ar.sum;
                flags_next = ar.flags;
                to_mem = (op_reg == ext_add_with_carry_to_mem);
                to_reg = !to_mem;
            end
            ext_add, ext_add_to_mem: begin
                // No carry in
                ar = add8(working_register, mem_rdata,
                    1'b0, status);
                res = ar.sum;
                flags_next = ar.flags;
                to_mem = (op_reg == ext_add_to_mem);
                to_reg = !to_mem;
            end
            ext_subtract_borrow, ext_subtract_borrow_to_mem: begin
                // Acc + ~m + c equals acc - m - ~c
                ar = add8(working_register, ~mem_rdata,
                    status.carry_flag, status);
                res = ar.sum;
                flags_next = ar.flags;
                flags_next.carry_zero_flag =
                    ar.flags.zero_flag && status.zero_flag;
                to_mem = (op_reg == ext_subtract_borrow_to_mem);
                to_reg = !to_mem;
            end
            ext_and, ext_and_to_mem: begin
                // Bitwise product, zero flag follows
                res = working_register & mem_rdata;
                flags_next.zero_flag = is_zero(res);
                to_mem = (op_reg == ext_and_to_mem);
                to_reg = !to_mem;
            end
            ext_or, ext_or_to_mem: begin
                // Bitwise sum, zero flag follows
                res = working_register | mem_rdata;
                flags_next.zero_flag = is_zero(res);
                to_mem = (op_reg == ext_or_to_mem);
                to_reg = !to_mem;
            end
            ext_clear: begin
                // Whole byte to zero, flags kept
                res = `EIA_ZERO_BYTE;
                to_mem = 1'b1;
            end
            ext_clear_bit: begin
                // Only the chosen bit drops
                res = mem_rdata & ~(`EIA_ONE_BYTE << bit_reg);
                to_mem = 1'b1;
            end
            ext_invert, ext_invert_to_reg: begin
                // Ones complement of the operand
                res = ~mem_rdata;
                flags_next.zero_flag = is_zero(res);
                to_reg = (op_reg == ext_invert_to_reg);
                to_mem = !to_reg;
            end
            ext_decimal_adjust: begin
                // Adjusted accumulator goes to memory
                res = daa_sum[7:0];
                flags_next.carry_flag = status.carry_flag
                    || hi_fix || daa_sum[8];
                to_mem = 1'b1;
            end
            ext_decrement, ext_decrement_to_reg: begin
                // Count down, wraps from zero
                res = mem_rdata - `EIA_ONE_BYTE;
                flags_next.zero_flag = is_zero(res);
                to_reg = (op_reg == ext_decrement_to_reg);
                to_mem = !to_reg;
            end
            ext_increment, ext_increment_to_reg: begin
                // Count up, wraps from all ones
                res = mem_rdata + `EIA_ONE_BYTE;
                flags_next.zero_flag = is_zero(res);
                to_reg = (op_reg == ext_increment_to_reg);
                to_mem = !to_reg;
            end
            ext_move: begin
                // Memory into register, flags untouched
                res = mem_rdata;
                to_reg = 1'b1;
            end
            ext_move_to_mem: begin
                // Register into memory, flags untouched
                res = working_register;
                to_mem = 1'b1;
            end
            ext_rotate_left, ext_rotate_left_to_reg: begin
                // Plain rotate, bit seven wraps to bit zero
                res = rot_left(mem_rdata, mem_rdata[`EIA_MSB]);
                to_reg = (op_reg == ext_rotate_left_to_reg);
                to_mem = !to_reg;
            end
            ext_rotate_left_carry, ext_rotate_left_carry_to_reg: begin
                // Old carry in at the bottom, bit seven out
                res = rot_left(mem_rdata, status.carry_flag);
                flags_next.carry_flag = mem_rdata[`EIA_MSB];
                to_reg = (op_reg == ext_rotate_left_carry_to_reg);
                to_mem = !to_reg;
            end
            ext_rotate_right, ext_rotate_right_to_reg: begin
                // Plain rotate, bit zero wraps to bit seven
                res = rot_right(mem_rdata, mem_rdata[`EIA_LSB]);
                to_reg = (op_reg == ext_rotate_right_to_reg);
                to_mem = !to_reg;
            end
            ext_rotate_right_carry, ext_rotate_right_carry_to_reg: begin
                // Old carry in at the top, bit zero out
                res = rot_right(mem_rdata, status.carry_flag);
                flags_next.carry_flag = mem_rdata[`EIA_LSB];
                to_reg = (op_reg == ext_rotate_right_carry_to_reg);
                to_mem = !to_reg;
            end
            default: begin
                // Unknown selector: no effect
                res = mem_rdata;
            end
        endcase
    end

    // Memory write back, one pulse in the execute cycle edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_wr_en <= 1'b0;
            mem_wdata <= `EIA_ZERO_BYTE;
        end else begin
            mem_wr_en <= (state_reg == eia_exec) && to_mem;
            if ((state_reg == eia_exec) && to_mem) begin
                mem_wdata <= res;
            end
        end
    end

    // Working register: core load or instruction result
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            working_register <= `EIA_ACC_RST;
        end else if ((state_reg == eia_exec) && to_reg) begin
            working_register <= res;
        end else if (state_load && ready) begin
            working_register <= state_load_acc;
        end
    end

    // Status flags: only listed flags change
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status <= '{default: `EIA_FLAG_RST};
        end else if (state_reg == eia_exec) begin
            status <= flags_next;
        end else if (state_load && ready) begin
            status <= state_load_flags;
        end
    end

    // Completion pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done <= 1'b0;
        end else begin
            done <= (state_reg == eia_exec);
        end
    end

endmodule

// ### src/eia_pkg.sv
package eia_pkg;

    // Instruction selector of the extended group
    typedef enum logic [4:0] {
        ext_add_with_carry,
        ext_add_with_carry_to_mem,
        ext_add,
        ext_add_to_mem,
        ext_and,
        ext_and_to_mem,
        ext_or,
        ext_or_to_mem,
        ext_clear,
        ext_clear_bit,
        ext_invert,
        ext_invert_to_reg,
        ext_decimal_adjust,
        ext_decrement,
        ext_decrement_to_reg,
        ext_increment,
        ext_increment_to_reg,
        ext_move,
        ext_move_to_mem,
        ext_rotate_left,
        ext_rotate_left_to_reg,
        ext_rotate_left_carry,
        ext_rotate_left_carry_to_reg,
        ext_rotate_right,
        ext_rotate_right_to_reg,
        ext_rotate_right_carry,
        ext_rotate_right_carry_to_reg,
        ext_subtract_borrow,
        ext_subtract_borrow_to_mem
    } eia_op_e;

    // Status flags
    typedef struct packed {
        logic twos_complement_range_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
        logic signed_carry_flag;
        logic carry_zero_flag;
    } eia_flags_s;

    // One instruction request
    typedef struct packed {
        eia_op_e op;
        logic [2:0] bit_sel;
    } eia_req_s;

    // Adder result with its flags
    typedef struct packed {
        logic [7:0] sum;
        eia_flags_s flags;
    } eia_sum_s;

endpackage

// ### tb/eia_ext_alu_checker.sv
`timescale 1ns/1ps
// Port-level checks of the extended ALU
module eia_ext_alu_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire eia_pkg::eia_req_s req,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic ready,
    input wire logic done,
    input wire logic mem_rd_en,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] working_register,
    input wire eia_pkg::eia_flags_s status
);
    import eia_pkg::*;
    eia_op_e op_reg; // Op in flight
    logic rd_dly_reg; // Read strobe one cycle late
    logic [7:0] rd_reg; // Operand as returned
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Latch the accepted op
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            op_reg <= ext_add;
        end else if (start && ready) begin
            op_reg <= req.op;
        end
    end
    // Capture the operand in its valid cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_dly_reg <= 1'b0;
            rd_reg <= 8'h00;
        end else begin
            rd_dly_reg <= mem_rd_en;
            if (rd_dly_reg) begin
                rd_reg <= mem_rdata;
            end
        end
    end
    property p_walk;
        start && ready |=> mem_rd_en && mem_addr == $past(req_addr)
            ##1 !mem_rd_en ##1 done ##1 ready;
    endproperty
    a_walk: assert property (p_walk) else $error("walk off");
    property p_no_flag;
        done && op_reg inside {ext_clear, ext_clear_bit, ext_move,
            ext_move_to_mem, ext_rotate_left, ext_rotate_right}
            |-> status == $past(status);
    endproperty
    a_no_flag: assert property (p_no_flag) else $error("flag moved");
    property p_zero_only;
        done && op_reg inside {ext_and, ext_or_to_mem, ext_invert,
            ext_decrement_to_reg, ext_increment}
            |-> ((status ^ $past(status)) & 6'h2f) == 6'h00;
    endproperty
    a_zero_only: assert property (p_zero_only)
        else $error("non-zero flag");
    property p_carry_only;
        done && op_reg inside {ext_decimal_adjust, ext_rotate_left_carry,
            ext_rotate_right_carry_to_reg}
            |-> ((status ^ $past(status)) & 6'h3b) == 6'h00;
    endproperty
    a_carry_only: assert property (p_carry_only)
        else $error("non-carry flag");
    property p_rlc;
        done && op_reg == ext_rotate_left_carry |-> mem_wr_en
            && mem_wdata == {rd_reg[6:0], $past(status.carry_flag)}
            && status.carry_flag == rd_reg[7];
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate carry left");
    property p_rrc;
        done && op_reg == ext_rotate_right_carry_to_reg |-> !mem_wr_en
            && working_register == {$past(status.carry_flag), rd_reg[7:1]}
            && status.carry_flag == rd_reg[0];
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate carry right");
    property p_sbc;
        done && op_reg == ext_subtract_borrow |-> status.carry_flag ==
            ({1'b0, $past(working_register)} >=
            {1'b0, rd_reg} + {8'h00, !$past(status.carry_flag)});
    endproperty
    a_sbc: assert property (p_sbc) else $error("borrow wrong");
    property p_clr;
        done && op_reg == ext_clear |-> mem_wr_en && mem_wdata == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("clear wrong");
endmodule

bind eia_ext_alu eia_ext_alu_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk(clk), .rstn(rstn), .start(start), .req(req),
    .req_addr(req_addr), .ready(ready), .done(done),
    .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
    .working_register(working_register), .status(status)
);

// ### tb/extended_instr_alu_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench of the extended ALU
module extended_instr_alu_tb_top;
    import eia_pkg::*;
    typedef struct packed {
        logic wr;
        logic [7:0] acc;
        logic [7:0] wd;
        eia_flags_s fl;
    } eia_exp_s;
    localparam int AW = 12; // Address width under test
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    eia_req_s req = '0;
    logic [AW-1:0] req_addr = '0;
    logic [7:0] mem_rdata = 8'h00;
    logic state_load = 1'b0;
    logic [7:0] state_load_acc = 8'h00;
    eia_flags_s state_load_flags = '0;
    logic ready, done, mem_rd_en, mem_wr_en;
    logic [AW-1:0] mem_addr;
    logic [7:0] mem_wdata, working_register, mem_val;
    eia_flags_s status;
    logic [31:0] seed = 32'h0001_7d37; // Random state
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    eia_op_e op;
    eia_ext_alu #(.ADDR_W(AW)) dut (
        .clk(clk), .rstn(rstn), .start(start), .req(req),
        .req_addr(req_addr), .ready(ready), .done(done),
        .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
        .state_load(state_load), .state_load_acc(state_load_acc),
        .state_load_flags(state_load_flags),
        .working_register(working_register), .status(status));
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Memory answers a cycle after the strobe, inverse otherwise
    always @(posedge clk) begin
        mem_rdata <= mem_rd_en ? mem_val : ~mem_val;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // Shift register step
    function automatic logic [31:0] rnd();
        seed = seed[0] ? (seed >> 1) ^ 32'h8020_0003 : seed >> 1;
        return seed;
    endfunction
    // Expected outcome of one instruction
    function automatic eia_exp_s expect_of(input eia_op_e o,
        input logic [7:0] a, input logic [7:0] m, input eia_flags_s f,
        input logic [2:0] b);
        eia_exp_s e;
        logic [8:0] s;
        logic [7:0] r, bb, t;
        logic ci;
        e = '{wr: 1'b0, acc: a, wd: 8'h00, fl: f};
        r = m;
        case (o)
            ext_add_with_carry, ext_add_with_carry_to_mem, ext_add,
            ext_add_to_mem, ext_subtract_borrow,
            ext_subtract_borrow_to_mem: begin
                bb = (o >= ext_subtract_borrow) ? ~m : m;
                ci = (o inside {ext_add, ext_add_to_mem}) ? 1'b0 : f.carry_flag;
                s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
                t = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
                r = s[7:0];
                e.fl.carry_flag = s[8];
                e.fl.twos_complement_range_flag = t[7] ^ s[8];
                e.fl.signed_carry_flag = t[7] ^ s[8] ^ r[7];
                e.fl.half_carry_flag = ({1'b0, a[3:0]} + {1'b0, bb[3:0]}
                    + {4'h0, ci}) > 5'h0f;
                e.fl.zero_flag = r == 8'h00;
                if (o >= ext_subtract_borrow) begin
                    e.fl.carry_zero_flag = (r == 8'h00) & f.zero_flag;
                end
            end
            ext_and, ext_and_to_mem: r = a & m;
            ext_or, ext_or_to_mem: r = a | m;
            ext_clear: r = 8'h00;
            ext_clear_bit: r[b] = 1'b0;
            ext_invert, ext_invert_to_reg: r = ~m;
            ext_decimal_adjust: begin
                bb = {(a[7:4] > 4'h9 || f.carry_flag) ? 4'h6 : 4'h0,
                    (a[3:0] > 4'h9 || f.half_carry_flag) ? 4'h6 : 4'h0};
                s = {1'b0, a} + {1'b0, bb};
                r = s[7:0];
                e.fl.carry_flag = f.carry_flag | bb[5] | s[8];
            end
            ext_decrement, ext_decrement_to_reg: r = m - 8'h01;
            ext_increment, ext_increment_to_reg: r = m + 8'h01;
            ext_move_to_mem: r = a;
            ext_rotate_left, ext_rotate_left_to_reg: r = {m[6:0], m[7]};
            ext_rotate_right, ext_rotate_right_to_reg: r = {m[0], m[7:1]};
            ext_rotate_left_carry, ext_rotate_left_carry_to_reg: begin
                r = {m[6:0], f.carry_flag};
                e.fl.carry_flag = m[7];
            end
            ext_rotate_right_carry, ext_rotate_right_carry_to_reg: begin
                r = {f.carry_flag, m[7:1]};
                e.fl.carry_flag = m[0];
            end
            default: r = m;
        endcase
        if (o inside {[ext_and:ext_or_to_mem], ext_invert, ext_invert_to_reg,
            [ext_decrement:ext_increment_to_reg]}) begin
            e.fl.zero_flag = r == 8'h00;
        end
        e.wr = !(o inside {ext_add_with_carry, ext_add, ext_and, ext_or,
            ext_invert_to_reg, ext_decrement_to_reg, ext_increment_to_reg,
            ext_move, ext_rotate_left_to_reg, ext_rotate_left_carry_to_reg,
            ext_rotate_right_to_reg, ext_rotate_right_carry_to_reg,
            ext_subtract_borrow});
        if (e.wr) begin
            e.wd = r;
        end else begin
            e.acc = r;
        end
        return e;
    endfunction
    // Value comparison
    task automatic cmp_val(input string n, input logic [11:0] e,
        input logic [11:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Load state, issue one op, check its results
    task automatic run_op(input eia_op_e o, input logic [7:0] a,
        input logic [7:0] m, input eia_flags_s f, input logic [AW-1:0] ad);
        eia_exp_s e;
        logic [2:0] b;
        b = 3'(rnd());
        e = expect_of(o, a, m, f, b);
        mem_val = m;
        state_load <= 1'b1;
        state_load_acc <= a;
        state_load_flags <= f;
        @(posedge clk);
        state_load <= 1'b0;
        start <= 1'b1;
        req <= '{op: o, bit_sel: b};
        req_addr <= ad;
        @(posedge clk);
        req <= '{op: ext_clear, bit_sel: b};
        req_addr <= ~ad;
        #1;
        cmp_val("mem_addr", 12'(ad), 12'(mem_addr));
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        #1;
        cmp_val("done", 12'h001, {11'h000, done});
        cmp_val("wr_en", {11'h000, e.wr}, {11'h000, mem_wr_en});
        if (e.wr) begin
            cmp_val("wdata", {4'h0, e.wd}, {4'h0, mem_wdata});
        end
        cmp_val("acc", {4'h0, e.acc}, {4'h0, working_register});
        cmp_val("flags", {6'h00, e.fl}, {6'h00, status});
        @(posedge clk);
    endtask
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmp_val("acc_rst", 12'h000, {4'h0, working_register});
        run_op(ext_decimal_adjust, 8'h9a, 8'h00, 6'h00, '0);
        run_op(ext_decimal_adjust, 8'h45, 8'h11, 6'h08, '1);
        run_op(ext_decimal_adjust, 8'h12, 8'h00, 6'h04, '0);
        run_op(ext_subtract_borrow, 8'h40, 8'h40, 6'h14, '1);
        run_op(ext_subtract_borrow_to_mem, 8'h00, 8'h01, 6'h04, '0);
        run_op(ext_add_with_carry, 8'hff, 8'h00, 6'h04, '1);
        run_op(ext_add_to_mem, 8'h7f, 8'h01, 6'h04, '0);
        // Mid-run reset clears register, flags and strobes
        rstn <= 1'b0;
        #1;
        cmp_val("acc_rst2", 12'h000, {4'h0, working_register});
        cmp_val("flags_rst", 12'h000, {6'h00, status});
        cmp_val("wr_en_rst", 12'h000, {11'h000, mem_wr_en});
        @(posedge clk);
        rstn <= 1'b1;
        run_op(ext_increment_to_reg, 8'h00, 8'hff, 6'h00, '1);
        // Random sweep over every op
        for (int p = 0; p < 6; p++) begin
            op = op.first();
            do begin
                run_op(op, 8'(rnd()), 8'(rnd()), 6'(rnd()),
                    12'(rnd()));
                op = op.next();
            end while (op != op.first());
        end
        tally_and_finish();
    end
endmodule
